// >>> rtl/lpx_responder.sv
// Purpose: Modulator-side latency probe responder with APB registers.
// Assumes: Probe fields arrive parsed, on mclk; local time is on mclk too.
// Notes: One probe in flight at a time, which also bounds each session to one.
`timescale 1ns/10ps
module lpx_responder #(
	parameter int SESSIONS = 8,
	parameter int SESS_W = 3,
	parameter logic [31:0] REPLY_LIMIT_CYCLES = lpx_pkg::PROBE_TIMER_CYC
) (
	// Clock and reset
	input wire logic mclk,
	input wire logic reset,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Local time and sync origination point
	input wire logic [31:0] sync_time,
	input wire logic sync_origin,
	// Incoming probe request
	input wire logic req_valid,
	output logic req_ready,
	input wire logic [SESS_W-1:0] req_session,
	input wire logic [2:0] req_flow,
	input wire logic [1:0] req_ext_hdr,
	input wire logic [7:0] req_code,
	input wire logic [7:0] req_probe_tag,
	input wire logic [31:0] req_ts_start,
	input wire logic [31:0] req_src_addr,
	// Outgoing probe reply
	output logic rep_valid,
	input wire logic rep_ready,
	output logic [SESS_W-1:0] rep_session,
	output logic [2:0] rep_flow,
	output logic [1:0] rep_ext_hdr,
	output logic [7:0] rep_code,
	output logic [7:0] rep_probe_tag,
	output logic [31:0] rep_ts_start,
	output logic [31:0] rep_ts_end,
	output logic [31:0] rep_dst_addr
);
	import lpx_pkg::*;
	// ==========================================
	// Declarations
	lpx_state_t state, next_state;
	logic [SESS_W-1:0] p_session, next_p_session;
	logic [2:0] p_flow, next_p_flow;
	logic [1:0] p_ext, next_p_ext;
	logic [7:0] p_code, next_p_code;
	logic [7:0] p_tag, next_p_tag;
	logic [31:0] p_ts_start, next_p_ts_start;
	logic [31:0] p_ts_end, next_p_ts_end;
	logic [31:0] p_src, next_p_src;
	logic [31:0] ctrl, next_ctrl;
	logic [31:0] sess_active, next_sess_active;
	logic [31:0] reply_limit, next_reply_limit;
	logic [31:0] reply_count, next_reply_count;
	logic [31:0] drop_count, next_drop_count;
	logic [31:0] timeout_count, next_timeout_count;
	logic [31:0] next_prdata;
	logic [SESSIONS-1:0] sess_on;
	logic wr_en, rd_setup, addr_hit;
	logic accept, timer_expire, reply_done;
	logic ev_reply, ev_drop, ev_timeout;
	logic clr_reply, clr_drop, clr_timeout;
	logic sess_ok, is_ingress, is_egress;
	// ==========================================
	// Session activity, one bit per session
	genvar g;
	generate
		for (g = 0; g < SESSIONS; g++) begin : g_sess
			assign sess_on[g] = sess_active[g];
		end
	endgenerate
	// ==========================================
	// Request decode
	assign accept = req_valid && req_ready;
	assign req_ready = (state == LPX_IDLE);
	assign sess_ok = sess_on[p_session] && ctrl[CTRL_ENABLE_BIT];
	assign is_ingress = (p_ext == EXT_HDR_PROBE) && (p_code == CODE_INGRESS_REQ);
	assign is_egress = (p_ext == EXT_HDR_PROBE) && (p_code == CODE_EGRESS_REQ);
	assign reply_done = rep_valid && rep_ready;
	assign rep_valid = (state == LPX_SEND);
	// ==========================================
	// Reply timer
	// Restarted by every accept, so a stale expiry never reaches a later probe
	lpx_reply_timer u_timer (
		.mclk(mclk),
		.reset(reset),
		.start(accept),
		.stop(reply_done),
		.limit(reply_limit),
		.expire(timer_expire)
	);
	// ==========================================
	// Probe state machine
	always_comb begin
		next_state = state;
		next_p_session = p_session;
		next_p_flow = p_flow;
		next_p_ext = p_ext;
		next_p_code = p_code;
		next_p_tag = p_tag;
		next_p_ts_start = p_ts_start;
		next_p_ts_end = p_ts_end;
		next_p_src = p_src;
		ev_reply = 1'b0;
		ev_drop = 1'b0;
		ev_timeout = 1'b0;
		case (state)
			LPX_IDLE: begin
				if (accept) begin
					next_p_session = req_session;
					next_p_flow = req_flow;
					next_p_ext = req_ext_hdr;
					next_p_code = req_code;
					next_p_tag = req_probe_tag;
					next_p_ts_start = req_ts_start;
					next_p_src = req_src_addr;
					// Stamped on arrival, ahead of any output queue
					next_p_ts_end = sync_time;
					next_state = LPX_CAPTURE;
				end
			end
			LPX_CAPTURE: begin
				if (sess_ok && is_ingress) begin
					next_p_code = CODE_INGRESS_REP;
					next_state = LPX_SEND;
				end else if (sess_ok && is_egress && ctrl[CTRL_EGRESS_BIT]) begin
					next_state = LPX_WAIT_SYNC;
				end else begin
					// Silent discard, nothing is sent
					ev_drop = 1'b1;
					next_state = LPX_IDLE;
				end
			end
			LPX_WAIT_SYNC: begin
				if (timer_expire) begin
					ev_timeout = 1'b1;
					next_state = LPX_IDLE;
				end else if (sync_origin) begin
					next_p_ts_end = sync_time;
					next_p_code = CODE_EGRESS_REP;
					next_state = LPX_SEND;
				end
			end
			LPX_SEND: begin
				if (reply_done) begin
					ev_reply = 1'b1;
					next_state = LPX_IDLE;
				end else if (timer_expire) begin
					// A late reply is useless to the sender, so it is withdrawn
					ev_timeout = 1'b1;
					next_state = LPX_IDLE;
				end
			end
			default: begin
				next_state = LPX_IDLE;
			end
		endcase
	end
	always_ff @(posedge mclk) begin
		if (reset) begin
			state <= LPX_IDLE;
			p_session <= '0;
			p_flow <= 3'h0;
			p_ext <= 2'h0;
			p_code <= 8'h00;
			p_tag <= 8'h00;
			p_ts_start <= 32'h0000_0000;
			p_ts_end <= 32'h0000_0000;
			p_src <= 32'h0000_0000;
		end else begin
			state <= next_state;
			p_session <= next_p_session;
			p_flow <= next_p_flow;
			p_ext <= next_p_ext;
			p_code <= next_p_code;
			p_tag <= next_p_tag;
			p_ts_start <= next_p_ts_start;
			p_ts_end <= next_p_ts_end;
			p_src <= next_p_src;
		end
	end
	// ==========================================
	// Reply fields, straight from the held probe
	assign rep_session = p_session;
	assign rep_flow = p_flow;
	assign rep_ext_hdr = p_ext;
	assign rep_code = p_code;
	assign rep_probe_tag = p_tag;
	assign rep_ts_start = p_ts_start;
	assign rep_ts_end = p_ts_end;
	assign rep_dst_addr = p_src;
	// ==========================================
	// APB decode
	assign wr_en = psel && penable && pwrite;
	assign rd_setup = psel && !penable && !pwrite;
	assign pready = 1'b1;
	always_comb begin
		case (paddr)
			REG_CTRL, REG_SESS_ACTIVE, REG_STATUS, REG_REPLY_COUNT,
			REG_DROP_COUNT, REG_TIMEOUT_COUNT, REG_REPLY_LIMIT: addr_hit = 1'b1;
			default: addr_hit = 1'b0;
		endcase
	end
	assign pslverr = psel && penable && !addr_hit;
	// Any write to a counter clears it
	assign clr_reply = wr_en && (paddr == REG_REPLY_COUNT);
	assign clr_drop = wr_en && (paddr == REG_DROP_COUNT);
	assign clr_timeout = wr_en && (paddr == REG_TIMEOUT_COUNT);
	// ==========================================
	// Configuration registers
	always_comb begin
		next_ctrl = ctrl;
		next_sess_active = sess_active;
		next_reply_limit = reply_limit;
		if (wr_en) begin
			case (paddr)
				REG_CTRL: next_ctrl = {30'h0, pwdata[CTRL_EGRESS_BIT], pwdata[CTRL_ENABLE_BIT]};
				REG_SESS_ACTIVE: next_sess_active = pwdata;
				// A zero limit would expire at once and starve every reply
				REG_REPLY_LIMIT: next_reply_limit = (pwdata == 32'h0000_0000) ? 32'h0000_0001 : pwdata;
				default: next_ctrl = ctrl;
			endcase
		end
	end
	always_ff @(posedge mclk) begin
		if (reset) begin
			ctrl <= CTRL_RESET;
			sess_active <= SESS_ACTIVE_RESET;
			reply_limit <= REPLY_LIMIT_CYCLES;
		end else begin
			ctrl <= next_ctrl;
			sess_active <= next_sess_active;
			reply_limit <= next_reply_limit;
		end
	end
	// ==========================================
	// Event counters; an event in the clearing cycle is still counted
	always_comb begin
		next_reply_count = reply_count;
		next_drop_count = drop_count;
		next_timeout_count = timeout_count;
		if (clr_reply) begin
			next_reply_count = 32'h0000_0000;
		end
		if (clr_drop) begin
			next_drop_count = 32'h0000_0000;
		end
		if (clr_timeout) begin
			next_timeout_count = 32'h0000_0000;
		end
		if (ev_reply) begin
			next_reply_count = clr_reply ? 32'h0000_0001 : reply_count + 32'h0000_0001;
		end
		if (ev_drop) begin
			next_drop_count = clr_drop ? 32'h0000_0001 : drop_count + 32'h0000_0001;
		end
		if (ev_timeout) begin
			next_timeout_count = clr_timeout ? 32'h0000_0001 : timeout_count + 32'h0000_0001;
		end
	end
	always_ff @(posedge mclk) begin
		if (reset) begin
			reply_count <= 32'h0000_0000;
			drop_count <= 32'h0000_0000;
			timeout_count <= 32'h0000_0000;
		end else begin
			reply_count <= next_reply_count;
			drop_count <= next_drop_count;
			timeout_count <= next_timeout_count;
		end
	end
	// ==========================================
	// Read data, latched at setup so it stands through the access phase
	always_comb begin
		next_prdata = prdata;
		if (rd_setup) begin
			case (paddr)
				REG_CTRL: next_prdata = ctrl;
				REG_SESS_ACTIVE: next_prdata = sess_active;
				// Busy flag above the state code
				REG_STATUS: next_prdata = {29'h0, (state != LPX_IDLE), state};
				REG_REPLY_COUNT: next_prdata = reply_count;
				REG_DROP_COUNT: next_prdata = drop_count;
				REG_TIMEOUT_COUNT: next_prdata = timeout_count;
				REG_REPLY_LIMIT: next_prdata = reply_limit;
				default: next_prdata = 32'h0000_0000;
			endcase
		end
	end
	always_ff @(posedge mclk) begin
		if (reset) begin
			prdata <= 32'h0000_0000;
		end else begin
			prdata <= next_prdata;
		end
	end
endmodule

// >>> rtl/lpx_pkg.sv
// Purpose: Constants, register map and types for the latency probe responder.
// Assumes: 200 MHz mclk, APB register access with 32-bit data.
// Notes: Shared by the responder top and the reply timer.
// Contract
// - Requester picks a per-session unique tag; responder returns it unchanged.
// - Responder fills the four-byte end timestamp with its local time.
// - Modulator answers ingress requests with ingress replies; egress optional.
// - Modulator serves any active session, one measurement per session.
// - End timestamp within 100 us of the sync insertion time.
// - Ingress end timestamp written before the probe enters output queues.
// - Egress end timestamp written at the sync origination point.
// - Completed probe goes back to its sender within the reply limit.
// - Without egress support an egress request is dropped with no reply.
// - Request to reply takes at most 100 ms at the modulator.
// - Probe code: 0 ingress req, 1 ingress reply, 2 egress req, 3 egress reply.
// - Probe extended-header bits are 01.
package lpx_pkg;
	// ==========================================
	// Timing
	localparam int CLK_MHZ = 200;
	localparam int PROBE_TIMER_MS = 100;
	localparam int PROBE_TIMER_CYC = PROBE_TIMER_MS * 1000 * CLK_MHZ;
	// ==========================================
	// Probe header encodings
	localparam logic [1:0] EXT_HDR_PROBE = 2'h1;
	localparam logic [7:0] CODE_INGRESS_REQ = 8'h00;
	localparam logic [7:0] CODE_INGRESS_REP = 8'h01;
	localparam logic [7:0] CODE_EGRESS_REQ = 8'h02;
	localparam logic [7:0] CODE_EGRESS_REP = 8'h03;
	// ==========================================
	// Register map, byte offsets
	localparam logic [11:0] REG_CTRL = 12'h000;
	localparam logic [11:0] REG_SESS_ACTIVE = 12'h004;
	localparam logic [11:0] REG_STATUS = 12'h008;
	localparam logic [11:0] REG_REPLY_COUNT = 12'h00c;
	localparam logic [11:0] REG_DROP_COUNT = 12'h010;
	localparam logic [11:0] REG_TIMEOUT_COUNT = 12'h014;
	localparam logic [11:0] REG_REPLY_LIMIT = 12'h018;
	// ==========================================
	// Control fields and reset values
	localparam int CTRL_ENABLE_BIT = 0;
	localparam int CTRL_EGRESS_BIT = 1;
	localparam logic [31:0] CTRL_RESET = 32'h0000_0001;
	localparam logic [31:0] SESS_ACTIVE_RESET = 32'h0000_0000;
	// ==========================================
	// Responder states, Gray along idle-capture-wait-send
	typedef enum logic [1:0] {
		LPX_IDLE = 2'b00,
		LPX_CAPTURE = 2'b01,
		LPX_WAIT_SYNC = 2'b11,
		LPX_SEND = 2'b10
	} lpx_state_t;
endpackage

// >>> rtl/lpx_reply_timer.sv
// Purpose: Counts cycles from request capture until the reply leaves.
// Assumes: Limit is stable while a probe is in flight.
// Notes: Expire is a one-cycle pulse; a new start restarts the count.
`timescale 1ns/10ps
module lpx_reply_timer (
	// Clock and reset
	input wire logic mclk,
	input wire logic reset,
	// Control
	input wire logic start,
	input wire logic stop,
	input wire logic [31:0] limit,
	// Status
	output logic expire
);
	import lpx_pkg::*;
	logic running;
	logic [31:0] count;
	logic next_running;
	logic [31:0] next_count;
	logic next_expire;
	// ==========================================
	// Counter
	always_comb begin
		next_running = running;
		next_count = count;
		next_expire = 1'b0;
		if (start) begin
			next_running = 1'b1;
			next_count = 32'h0000_0001;
		end else if (stop) begin
			next_running = 1'b0;
		end else if (running) begin
			if (count >= limit) begin
				next_running = 1'b0;
				next_expire = 1'b1;
			end else begin
				next_count = count + 32'h0000_0001;
			end
		end
	end
	always_ff @(posedge mclk) begin
		if (reset) begin
			running <= 1'b0;
			count <= 32'h0000_0000;
			expire <= 1'b0;
		end else begin
			running <= next_running;
			count <= next_count;
			expire <= next_expire;
		end
	end
endmodule

// >>> verification/lpx_responder_sva.sv
// Purpose: Port-level checks of the latency probe responder.
// Assumes: One clock domain, synchronous active-high reset.
// Notes: Probe fields captured at accept; one probe in flight.
`timescale 1ns/10ps
module lpx_responder_chk (
	// Clock and reset
	input wire logic mclk,
	input wire logic reset,
	// Time
	input wire logic [31:0] sync_time,
	input wire logic sync_origin,
	// Request
	input wire logic req_valid,
	input wire logic req_ready,
	input wire logic [7:0] req_code,
	input wire logic [7:0] req_probe_tag,
	input wire logic [31:0] req_ts_start,
	input wire logic [31:0] req_src_addr,
	// Reply
	input wire logic rep_valid,
	input wire logic rep_ready,
	input wire logic [1:0] rep_ext_hdr,
	input wire logic [7:0] rep_code,
	input wire logic [7:0] rep_probe_tag,
	input wire logic [31:0] rep_ts_start,
	input wire logic [31:0] rep_ts_end,
	input wire logic [31:0] rep_dst_addr
);
	default clocking @(posedge mclk); endclocking
	default disable iff (reset);
	// ==========================================
	// Capture at accept
	logic [7:0] cap_code, cap_tag;
	logic [31:0] cap_ts, cap_src, cap_time;
	always_ff @(posedge mclk) begin
		if (req_valid && req_ready) begin
			cap_code <= req_code;
			cap_tag <= req_probe_tag;
			cap_ts <= req_ts_start;
			cap_src <= req_src_addr;
			cap_time <= sync_time;
		end
	end
	// ==========================================
	// Reply relations
	AST_TAG: assert property (rep_valid |-> rep_probe_tag == cap_tag) else $error("tag changed");
	AST_DST: assert property (rep_valid |-> rep_dst_addr == cap_src && rep_ts_start == cap_ts)
		else $error("reply address or start time wrong");
	AST_CODE: assert property (rep_valid |-> cap_code[7:2] == 6'h0 && !cap_code[0] && rep_code == (cap_code | 8'h01))
		else $error("reply code wrong");
	AST_HDR: assert property (rep_valid |-> rep_ext_hdr == 2'h1) else $error("ext header wrong");
	AST_ING: assert property ($rose(rep_valid) && rep_code == 8'h01 |-> $past(req_valid && req_ready, 2)
		&& rep_ts_end == cap_time) else $error("ingress reply timing");
	AST_EGR: assert property ($rose(rep_valid) && rep_code == 8'h03 |-> $past(sync_origin)
		&& rep_ts_end == $past(sync_time)) else $error("egress reply timing");
	AST_ONE: assert property (req_valid && req_ready |=> !req_ready) else $error("accepting while busy");
	AST_HOLD: assert property (rep_valid && !rep_ready |=> !rep_valid || $stable(rep_ts_end) && $stable(rep_code))
		else $error("reply changed while stalled");
endmodule
bind lpx_responder lpx_responder_chk i_chk (.mclk(mclk), .reset(reset), .sync_time(sync_time),
	.sync_origin(sync_origin), .req_valid(req_valid), .req_ready(req_ready), .req_code(req_code),
	.req_probe_tag(req_probe_tag), .req_ts_start(req_ts_start), .req_src_addr(req_src_addr),
	.rep_valid(rep_valid), .rep_ready(rep_ready), .rep_ext_hdr(rep_ext_hdr), .rep_code(rep_code),
	.rep_probe_tag(rep_probe_tag), .rep_ts_start(rep_ts_start), .rep_ts_end(rep_ts_end),
	.rep_dst_addr(rep_dst_addr));

// >>> verification/lpx_core_model.sv
// Purpose: Core node model issuing probes and taking replies.
// Assumes: Shares mclk and the timestamp with the responder.
// Notes: Released request tag and start time show inverted data; the other request fields keep the old value.
`timescale 1ns/10ps
module lpx_core_model (
	// Clock and time
	input wire logic mclk,
	input wire logic [31:0] sync_time,
	// Request
	output logic req_valid,
	input wire logic req_ready,
	output logic [2:0] req_session,
	output logic [2:0] req_flow,
	output logic [1:0] req_ext_hdr,
	output logic [7:0] req_code,
	output logic [7:0] req_probe_tag,
	output logic [31:0] req_ts_start,
	output logic [31:0] req_src_addr,
	// Reply
	input wire logic rep_valid,
	output logic rep_ready,
	input wire logic [7:0] rep_code,
	input wire logic [7:0] rep_probe_tag,
	input wire logic [31:0] rep_ts_end
);
	logic [31:0] acc_time = 32'h0;
	initial begin
		{req_valid, req_session, req_flow, req_ext_hdr, req_code, req_probe_tag} = '0;
		{req_ts_start, req_src_addr, rep_ready} = '0;
	end
	// Task returns only when the probe is closed: one outstanding at a time
	task automatic probe(input logic [2:0] s, input logic [1:0] h, input logic [7:0] c, input logic [7:0] t,
		input int stall, output logic [7:0] code_o, output logic [31:0] end_o);
		int n;
		code_o = 8'hff;
		end_o = 32'h0;
		@(posedge mclk);
		req_valid <= 1'b1;
		req_session <= s;
		req_flow <= t[2:0];
		req_ext_hdr <= h;
		req_code <= c;
		req_probe_tag <= t;
		req_ts_start <= sync_time;
		req_src_addr <= {24'h0a0001, t};
		do begin
			@(posedge mclk);
		end while (req_ready !== 1'b1);
		acc_time = sync_time;
		req_valid <= 1'b0;
		req_probe_tag <= ~t;
		req_ts_start <= ~req_ts_start;
		for (n = 0; n < 80 && code_o == 8'hff; n++) begin
			@(posedge mclk);
			if (rep_valid === 1'b1 && rep_ready === 1'b1) begin
				code_o = (rep_probe_tag === t) ? rep_code : 8'hee;
				end_o = rep_ts_end;
				rep_ready <= 1'b0;
			end else begin
				rep_ready <= (n >= stall && n < 79);
			end
		end
	endtask
endmodule

// >>> verification/latency_probe_exchange_tb.sv
// Purpose: Self-checking bench for the latency probe responder.
// Assumes: Reply limit shortened to 50 cycles.
// Notes: Random probes from an LFSR plus register and timing corners.
`timescale 1ns/10ps
module latency_probe_exchange_tb;
	import lpx_pkg::*;
	logic mclk = 1'b0, reset = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, sync_origin = 1'b0;
	logic [11:0] paddr = 12'h0;
	logic [31:0] pwdata = 32'h0, sync_time = 32'h0, prdata, rs, ts, ad, lf = 32'hfef47c61;
	logic pready, pslverr, rq_v, rq_r, rp_v, rp_r, er;
	logic [2:0] se, fl, rse, rfl;
	logic [1:0] hd, rhd;
	logic [7:0] cd, tg, rcd, rtg, got, ex;
	int err_total = 0, checks_done = 0;
	lpx_responder #(.REPLY_LIMIT_CYCLES(32'd50)) i_lpx_responder (.mclk(mclk), .reset(reset), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .sync_time(sync_time), .sync_origin(sync_origin), .req_valid(rq_v), .req_ready(rq_r),
		.req_session(se), .req_flow(fl), .req_ext_hdr(hd), .req_code(cd), .req_probe_tag(tg), .req_ts_start(ts),
		.req_src_addr(ad), .rep_valid(rp_v), .rep_ready(rp_r), .rep_session(rse), .rep_flow(rfl),
		.rep_ext_hdr(rhd), .rep_code(rcd), .rep_probe_tag(rtg), .rep_ts_start(), .rep_ts_end(rs), .rep_dst_addr());
	lpx_core_model i_core (.mclk(mclk), .sync_time(sync_time), .req_valid(rq_v), .req_ready(rq_r),
		.req_session(se), .req_flow(fl), .req_ext_hdr(hd), .req_code(cd), .req_probe_tag(tg), .req_ts_start(ts),
		.req_src_addr(ad), .rep_valid(rp_v), .rep_ready(rp_r), .rep_code(rcd), .rep_probe_tag(rtg), .rep_ts_end(rs));
	initial forever #2.5 mclk = ~mclk;
	always @(posedge mclk) sync_time <= sync_time + 32'h1;
	// ==========================================
	// Helpers
	function automatic logic [31:0] lfsr(logic [31:0] x);
		return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
	endfunction
	function automatic logic [7:0] exp_code(logic [2:0] s, logic [1:0] h, logic [7:0] c, logic eg);
		if (s == 3'h7 || h != 2'h1) return 8'hff;
		if (c == CODE_INGRESS_REQ) return CODE_INGRESS_REP;
		if (c == CODE_EGRESS_REQ && eg) return CODE_EGRESS_REP;
		return 8'hff;
	endfunction
	task automatic check(input logic [31:0] seen, input logic [31:0] want);
		checks_done++;
		if (seen !== want) begin
			err_total++;
			$display("mismatch at %0t: got %h expected %h", $time, seen, want);
		end
	endtask
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] q);
		@(posedge mclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge mclk);
		penable <= 1'b1;
		do begin
			@(posedge mclk);
		end while (pready !== 1'b1);
		q = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic stop_test();
		$display("checks %0d mismatches %0d", checks_done, err_total);
		if (err_total == 0 && checks_done > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask
	initial begin
		repeat (20000) @(posedge mclk);
		err_total++;
		stop_test();
	end
	// ==========================================
	// Main sequence
	initial begin
		logic [31:0] q, e;
		logic [7:0] c;
		logic [1:0] h;
		int nd;
		repeat (6) @(posedge mclk);
		reset <= 1'b0;
		apb(1'b0, REG_CTRL, 32'h0, q); check(q, CTRL_RESET);
		apb(1'b0, REG_SESS_ACTIVE, 32'h0, q); check(q, SESS_ACTIVE_RESET);
		apb(1'b0, REG_REPLY_LIMIT, 32'h0, q); check(q, 32'd50);
		apb(1'b0, 12'h01c, 32'h0, q); check(q, 32'h0);
		check({31'h0, er}, 32'h1);
		apb(1'b1, REG_SESS_ACTIVE, 32'h7f, q);
		$display("test registers done");
		nd = 0;
		for (int i = 0; i < 14; i++) begin
			lf = lfsr(lf);
			ex = lf[18] ? 8'h00 : {5'h0, lf[2:0]};
			h = lf[18] ? 2'h1 : lf[4:3];
			c = exp_code(lf[7:5], h, ex, 1'b0);
			i_core.probe(lf[7:5], h, ex, lf[15:8], lf[17:16], got, q);
			check(got, c);
			if (c == 8'hff) begin
				nd++;
			end else begin
				check(q, i_core.acc_time);
				check({rse, rfl, rhd}, {lf[7:5], lf[10:8], 2'h1});
			end
		end
		apb(1'b0, REG_DROP_COUNT, 32'h0, q);
		check(q, nd);
		apb(1'b0, REG_REPLY_COUNT, 32'h0, q);
		check(q, 14 - nd);
		$display("test random done");
		apb(1'b1, REG_CTRL, 32'h3, q);
		fork
			i_core.probe(3'h1, 2'h1, CODE_EGRESS_REQ, 8'h5a, 1, got, q);
			begin
				repeat (6) @(posedge mclk);
				sync_origin <= 1'b1;
				@(posedge mclk);
				e = sync_time;
				sync_origin <= 1'b0;
			end
		join
		check(got, CODE_EGRESS_REP);
		check(q, e);
		check({rse, rfl, rhd}, {3'h1, 3'h2, 2'h1});
		$display("test egress done");
		i_core.probe(3'h2, 2'h1, CODE_INGRESS_REQ, 8'h33, 70, got, q);
		check(got, 8'hff);
		apb(1'b0, REG_TIMEOUT_COUNT, 32'h0, q); check(q, 32'h1);
		$display("test timeout done");
		stop_test();
	end
endmodule
